// file: pkg/cxf_pkg.sv
// Shared constants and carrier types of the transceiver supervision logic.
// Assumes a single 10 MHz system clock and synchronous pin inputs.
package cxf_pkg;
  // System clock rate in MHz.
  localparam int unsigned CLK_MHZ        = 10;
  // Transmit-dominant timeout in microseconds.
  localparam int unsigned TXD_TO_US      = 1000;
  // Bus-dominant timeout in microseconds.
  localparam int unsigned BUS_TO_US      = 1000;
  // Mode input filter time in microseconds.
  localparam int unsigned IO_FILT_US     = 1;
  // Least wake filter time in microseconds.
  localparam int unsigned WAKE_MIN_US    = 5;
  // Cycle counts derived from the times above.
  localparam int unsigned TXD_TO_CYC     = TXD_TO_US * CLK_MHZ;
  localparam int unsigned BUS_TO_CYC     = BUS_TO_US * CLK_MHZ;
  localparam int unsigned IO_FILT_CYC    = IO_FILT_US * CLK_MHZ;
  localparam int unsigned WAKE_FILT_CYC  = WAKE_MIN_US * CLK_MHZ;
  // Timer width used by every counter.
  localparam int unsigned TMR_W          = 16;
  // Input bias controls, one bit per pin resistor.
  typedef struct packed {
    logic wake_pull_up;   // Wake pin pulled to battery.
    logic wake_pull_down; // Wake pin pulled to ground.
    logic txd_pull_up;    // Transmit input pulled recessive.
    logic stb_pull_down;  // Standby input pulled low.
    logic en_pull_down;   // Enable input pulled low.
  } cxf_bias_s;
  // Reset value of the bias controls.
  localparam cxf_bias_s BIAS_RST = 5'h0e;
endpackage

// file: rtl/cxf_fault_wake.sv
// Fault supervision, wake qualification and mode input filtering.
// Assumes every input is synchronous to clk_sys.
//
// Notes on behaviour
// - Any of four failures sets local failure.
// - Transmit timer starts when transmit goes low.
// - Long dominant transmit disables transmitter until cleared.
// - Transmit timer resets when transmit goes high.
// - Transmit-receive short disables transmitter until cleared.
// - Long bus dominant sets local failure.
// - Bus clamping never disables the transmitter.
// - Bus clamping flag drops once bus recessive.
// - Overtemperature disables both bus drivers.
// - Transmitter re-enable needs cool temperature and cleared flag; bus drivers need cool temperature only.
// - Short pulses on mode inputs are filtered.
// - Either wake edge may register a wake.
// - Wake accepted after level stable filter time.
// - No wake for levels shorter than minimum.
// - Wake bias follows pin after filter delay.
// - High wake pulls up, low pulls down.
// - Floating inputs default safe; enable pull needs battery.
// - Flag clears on power-on, normal entry, receive dominant.
// - Error output low means flag set.
// - Wake flag set only in standby or sleep, or by power-on.
`timescale 1ns/1ps

// Holds its output until the input has been stable for CYC cycles.
module cxf_filt import cxf_pkg::*; #(
  parameter int unsigned CYC = 1
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout_r
);
  // Last count before the input is adopted.
  localparam logic [TMR_W-1:0] LAST = TMR_W'(CYC - 1);
  logic [TMR_W-1:0] cnt_r;   // Cycles the input has differed.
  logic [TMR_W-1:0] cnt_nxt; // Next value of the counter.
  wire              differ = din != dout_r;
  wire              done   = differ && cnt_r == LAST;
  // The counter restarts whenever the input agrees again.
  assign cnt_nxt = (!differ || done) ? '0 : cnt_r + 1'b1;

  // Count while the input differs, adopt it once stable long enough.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Inputs read low until proven otherwise.
      cnt_r  <= '0;
      dout_r <= 1'b0;
    end else begin
      // Advance the count and adopt a settled level.
      cnt_r  <= cnt_nxt;
      dout_r <= done ? din : dout_r;
    end
  end
endmodule

// Top of the supervision logic.
module cxf_fault_wake import cxf_pkg::*; #(
  parameter int unsigned TXD_TO = TXD_TO_CYC,
  parameter int unsigned BUS_TO = BUS_TO_CYC
) (
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  input  wire logic  txd,                // Transmit input, low is dominant.
  input  wire logic  bus_dominant,       // Receiver sees dominant bus.
  input  wire logic  rxd_sense,          // Level read back on receive pin.
  input  wire logic  over_temp,          // Above shutdown temperature.
  input  wire logic  below_release_temp, // Below release temperature.
  input  wire logic  pwon_flag,          // Power-on flag is set.
  input  wire logic  mode_normal,        // Mode logic is in Normal mode.
  input  wire logic  mode_low_power,     // Mode logic in Standby or Sleep.
  input  wire logic  vbat_present,       // Battery supply present.
  input  wire logic  standby_select_n,   // Raw standby mode input.
  input  wire logic  enable_in,          // Raw enable mode input.
  input  wire logic  local_wake_level,   // Wake pin above threshold.
  output logic       tx_enable_r,        // Transmitter may drive.
  output logic       bus_drv_enable_r,   // Both bus drivers powered.
  output logic       rxd_out_r,          // Receive pin drive level.
  output logic       local_fail_r,       // Local failure flag.
  output logic       error_n_r,          // Flag on error pin, low set.
  output logic       wake_flag_r,        // Local wake-up flag.
  output logic       standby_filt_n,     // Filtered standby input.
  output logic       enable_filt,        // Filtered enable input.
  output cxf_bias_s  bias_r              // Pin bias resistor controls.
);
  // Timeout limits at the counter width.
  localparam logic [TMR_W-1:0] TXD_LIM = TMR_W'(TXD_TO);
  localparam logic [TMR_W-1:0] BUS_LIM = TMR_W'(BUS_TO);

  logic [TMR_W-1:0] txd_cnt_r;  // Transmit low time.
  logic [TMR_W-1:0] bus_cnt_r;  // Bus dominant time.
  logic             short_r;    // Short seen in the previous cycle.
  logic             tx_fail_r;  // Latched cause that blocks transmit.
  logic             bus_fail_r; // Bus clamping failure present.
  logic             ot_hold_r;  // Overtemperature not yet released.
  logic             normal_d_r; // Normal mode one cycle ago.
  logic             wake_d_r;   // Filtered wake level one cycle ago.
  logic             wake_filt;  // Filtered wake pin level.

  // Mode inputs and the wake pin each pass a stability filter.
  cxf_filt #(.CYC(IO_FILT_CYC)) u_stb (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (standby_select_n),
    .dout_r  (standby_filt_n)
  );
  // Enable input filter, same time as the standby filter.
  cxf_filt #(.CYC(IO_FILT_CYC)) u_en (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (enable_in),
    .dout_r  (enable_filt)
  );
  // Wake pin filter, much longer than the mode filters.
  cxf_filt #(.CYC(WAKE_FILT_CYC)) u_wake (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (local_wake_level),
    .dout_r  (wake_filt)
  );

  // Timers run while the condition lasts and saturate at their limit.
  wire txd_fail_now = !txd && txd_cnt_r == TXD_LIM;
  wire bus_fail_now = bus_cnt_r == BUS_LIM;
  wire [TMR_W-1:0] txd_cnt_nxt = txd ? '0 :
                     (txd_fail_now ? txd_cnt_r : txd_cnt_r + 1'b1);
  wire [TMR_W-1:0] bus_cnt_nxt = !bus_dominant ? '0 :
                     (bus_fail_now ? bus_cnt_r : bus_cnt_r + 1'b1);
  // A short shows as the receive pin low while driven recessive.
  wire short_now  = rxd_out_r && !rxd_sense;
  wire short_fail = short_now && short_r;
  // Any blocking cause latches until the flag is cleared.
  wire block_set  = txd_fail_now || short_fail || over_temp;
  wire resolved   = txd && !short_now && !ot_hold_r && !over_temp;
  wire enter_norm = mode_normal && !normal_d_r;
  wire flag_clr   = pwon_flag ||
                    (resolved && (enter_norm || (bus_dominant && txd)));
  // A set cause always wins over a clear in the same cycle.
  wire tx_fail_nxt  = block_set || (tx_fail_r && !flag_clr);
  // Clamping needs the bus still dominant, so recessive drops it at once.
  wire bus_fail_nxt = bus_fail_now && bus_dominant && !pwon_flag;
  // Overtemperature hold waits for the release threshold.
  wire ot_hold_nxt  = over_temp || (ot_hold_r && !below_release_temp);
  wire fail_nxt     = tx_fail_nxt || bus_fail_nxt;
  // Wake edges count only in low power modes.
  wire wake_edge    = wake_filt != wake_d_r;
  wire wake_nxt     = (wake_edge && mode_low_power) ||
                      pwon_flag || (wake_flag_r && !enter_norm);
  // Wake bias follows the filtered level, enable pull follows the battery, the other pulls are fixed.
  cxf_bias_s bias_nxt;
  assign bias_nxt.wake_pull_up   = wake_filt;
  assign bias_nxt.wake_pull_down = !wake_filt;
  assign bias_nxt.txd_pull_up    = 1'b1;
  assign bias_nxt.stb_pull_down  = 1'b1;
  assign bias_nxt.en_pull_down   = vbat_present;

  // Timers and detector history.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Timers idle and no history.
      txd_cnt_r  <= '0;
      bus_cnt_r  <= '0;
      short_r    <= 1'b0;
      normal_d_r <= 1'b0;
      wake_d_r   <= 1'b0;
    end else begin
      // Timers and history follow their next values.
      txd_cnt_r  <= txd_cnt_nxt;
      bus_cnt_r  <= bus_cnt_nxt;
      short_r    <= short_now;
      normal_d_r <= mode_normal;
      wake_d_r   <= wake_filt;
    end
  end

  // Failure flags; a new transmit blocking cause wins over a clear in the same cycle, power-on wins over bus clamping.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // No failure known, error pin released high.
      tx_fail_r    <= 1'b0;
      bus_fail_r   <= 1'b0;
      ot_hold_r    <= 1'b0;
      local_fail_r <= 1'b0;
      error_n_r    <= 1'b1;
    end else begin
      // Flag and pin move together from the same next value.
      tx_fail_r    <= tx_fail_nxt;
      bus_fail_r   <= bus_fail_nxt;
      ot_hold_r    <= ot_hold_nxt;
      local_fail_r <= fail_nxt;
      error_n_r    <= !fail_nxt;
    end
  end

  // Driver enables; bus clamping takes no part in them.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Drivers stay off while in reset.
      tx_enable_r      <= 1'b0;
      bus_drv_enable_r <= 1'b0;
      rxd_out_r        <= 1'b1;
    end else begin
      // Enables react in the same edge as the flags.
      tx_enable_r      <= !tx_fail_nxt && !ot_hold_nxt;
      bus_drv_enable_r <= !ot_hold_nxt;
      rxd_out_r        <= !bus_dominant;
    end
  end

  // Wake flag and pin bias.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // No wake pending, wake pin pulled down.
      wake_flag_r <= 1'b0;
      bias_r      <= BIAS_RST;
    end else begin
      // Flag and bias follow their next values.
      wake_flag_r <= wake_nxt;
      bias_r      <= bias_nxt;
    end
  end

  // Every check below runs on the system clock and sleeps in reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Transmit held low past the timeout drops the transmitter.
  a_txd_timeout: assert property (
    !txd && txd_cnt_r == TXD_LIM |=> !tx_enable_r && local_fail_r)
    else $error("transmit timeout did not disable transmitter");
  // Transmit timer restarts when transmit returns high.
  a_txd_timer_rst: assert property (
    txd |=> txd_cnt_r == '0)
    else $error("transmit timer not reset");
  // Timer counts up while transmit stays low.
  a_txd_timer_run: assert property (
    !txd && !$past(txd) && txd_cnt_r < TXD_LIM |=> txd_cnt_r != '0)
    else $error("transmit timer not running");
  // Bus clamping alone never drops the transmitter.
  a_bus_no_block: assert property (
    bus_fail_r && !tx_fail_r && !ot_hold_r |-> tx_enable_r)
    else $error("bus clamping disabled transmitter");
  // Bus clamping flag follows the bus back to recessive.
  a_bus_release: assert property (
    $fell(bus_dominant) |=> !bus_fail_r)
    else $error("bus clamping flag stuck");
  // Overtemperature drops both drivers at the next edge.
  a_ot_drivers: assert property (
    over_temp |=> !bus_drv_enable_r && !tx_enable_r)
    else $error("drivers active during overtemperature");
  // Error pin is the inverse of the failure flag.
  a_err_level: assert property (
    error_n_r == !local_fail_r)
    else $error("error pin does not mirror flag");
  // Wake flag rises only in low power modes or at power-on.
  a_wake_mode: assert property (
    $rose(wake_flag_r) |-> $past(mode_low_power) || $past(pwon_flag))
    else $error("wake flag set outside low power mode");
  // Wake bias never pulls both ways.
  a_wake_bias: assert property (
    bias_r.wake_pull_up != bias_r.wake_pull_down)
    else $error("wake bias inconsistent");
  // Power-on clears the transmit blocking cause.
  a_pwon_clear: assert property (
    pwon_flag && !block_set |=> !tx_fail_r)
    else $error("power-on did not clear failure");
  // Two cycles of pin short drop the transmitter.
  a_short_block: assert property (
    short_now && short_r |=> !tx_enable_r && local_fail_r)
    else $error("pin short did not disable transmitter");
  // Bus dominant past the timeout raises the flag.
  a_bus_set: assert property (
    bus_dominant && bus_cnt_r == BUS_LIM && !pwon_flag |=> local_fail_r)
    else $error("bus clamping not flagged");
  // Any blocking cause raises the flag and pulls the error pin low.
  a_fail_any: assert property (
    block_set |=> local_fail_r && !error_n_r)
    else $error("failure cause not flagged");
  // Transmitter stays off until the release temperature is reached.
  a_ot_hold: assert property (
    ot_hold_r && !below_release_temp |=> !tx_enable_r)
    else $error("transmitter back while still hot");
  // A mode input that agrees with its filter cannot move it.
  a_mode_filter: assert property (
    standby_select_n == standby_filt_n && enable_in == enable_filt
    |=> $stable(standby_filt_n) && $stable(enable_filt))
    else $error("mode filter passed a glitch");
  // A new wake level must have stood on the pin for many cycles.
  a_wake_adopt: assert property (
    $changed(wake_filt) |-> wake_filt == $past(local_wake_level)
    && wake_filt == $past(local_wake_level, 8))
    else $error("wake filter adopted an unsettled level");
  // Enable pull-down follows the battery supply.
  a_en_pull: assert property (
    1'b1 |=> bias_r.en_pull_down == $past(vbat_present))
    else $error("enable pull-down ignores supply");

  // Cover points for the main scenarios.
  c_txd_timeout: cover property (txd_cnt_r == TXD_LIM);
  c_short_block: cover property (short_fail);
  c_bus_clamp:   cover property ($rose(bus_fail_r));
  c_wake_set:    cover property (wake_edge && mode_low_power);
  c_ot_release:  cover property ($fell(ot_hold_r));
endmodule

// file: bench/cxf_host_model.sv
// Host controller model on the transmit and receive pins.
// Assumes the bench sets the wanted level and the pin short switch.
`timescale 1ns/1ps
module cxf_host_model (
  input  wire logic txd_req,   // Level the controller drives.
  input  wire logic short_en,  // Receive and transmit pins tied together.
  input  wire logic rxd_out_r, // Level the block drives on receive.
  output logic      txd,       // Transmit pin as the block sees it.
  output logic      rxd_sense  // Receive pin level read back.
);
  // A tied pin pair settles to the low of the two drivers.
  assign txd = short_en ? (txd_req & rxd_out_r) : txd_req;
  // The read back shows the controller pulling the pin low.
  assign rxd_sense = short_en ? (txd_req & rxd_out_r) : rxd_out_r;
endmodule

// file: bench/tb.sv
// Self-checking bench of the supervision logic, one task per scenario.
// Assumes a 10 MHz clock and timeouts shortened to TO cycles.
`timescale 1ns/1ps
module tb import cxf_pkg::*; ;
  localparam int unsigned TO = 20; // Shortened timeouts.
  logic      clk_sys = 1'b0, arst_n = 1'b0, txd_req = 1'b1;
  logic      short_en = 1'b0, bus_dominant = 1'b0, over_temp = 1'b0;
  logic      below_release_temp = 1'b1, pwon_flag = 1'b0;
  logic      mode_normal = 1'b0, mode_low_power = 1'b0;
  logic      vbat_present = 1'b1, standby_select_n = 1'b0;
  logic      enable_in = 1'b0, local_wake_level = 1'b0;
  wire       txd, rxd_sense, tx_enable_r, bus_drv_enable_r, rxd_out_r;
  wire       local_fail_r, error_n_r, wake_flag_r;
  wire       standby_filt_n, enable_filt;
  cxf_bias_s bias_r;
  int        fail_count = 0, comparisons = 0, cycles = 0;
  // Free running clock.
  always #50 clk_sys = ~clk_sys;
  cxf_host_model i_host (.txd_req(txd_req), .short_en(short_en),
    .rxd_out_r(rxd_out_r), .txd(txd), .rxd_sense(rxd_sense));
  cxf_fault_wake #(.TXD_TO(TO), .BUS_TO(TO)) i_dut (.clk_sys(clk_sys),
    .arst_n(arst_n), .txd(txd), .bus_dominant(bus_dominant),
    .rxd_sense(rxd_sense), .over_temp(over_temp),
    .below_release_temp(below_release_temp), .pwon_flag(pwon_flag),
    .mode_normal(mode_normal), .mode_low_power(mode_low_power),
    .vbat_present(vbat_present), .standby_select_n(standby_select_n),
    .enable_in(enable_in), .local_wake_level(local_wake_level),
    .tx_enable_r(tx_enable_r), .bus_drv_enable_r(bus_drv_enable_r),
    .rxd_out_r(rxd_out_r), .local_fail_r(local_fail_r),
    .error_n_r(error_n_r), .wake_flag_r(wake_flag_r),
    .standby_filt_n(standby_filt_n), .enable_filt(enable_filt),
    .bias_r(bias_r));
  // Waits n edges, then steps just past the edge to drive and sample.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  // Compares one flag.
  task automatic chk(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // Compares the whole bias control word.
  task automatic chk_bias(input cxf_bias_s got, input cxf_bias_s exp,
                          input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A rising edge of Normal mode, leaving low power mode.
  task automatic pulse_normal();
    mode_low_power = 1'b0;
    mode_normal = 1'b1;
    cyc(1);
    mode_normal = 1'b0;
    cyc(3);
  endtask
  // Values in and after reset, and the supply gated enable pull.
  task automatic t_reset();
    chk_bias(bias_r, BIAS_RST, "bias in reset");
    arst_n = 1'b1;
    cyc(2);
    chk(tx_enable_r, 1'b1, "tx after reset");
    chk(bias_r.en_pull_down, 1'b1, "enable pull");
    vbat_present = 1'b0;
    cyc(2);
    chk(bias_r.en_pull_down, 1'b0, "enable pull no supply");
    vbat_present = 1'b1;
  endtask
  // Short mode pulses vanish, long ones pass.
  task automatic t_filter();
    {standby_select_n, enable_in} = 2'h3;
    cyc(5);
    {standby_select_n, enable_in} = 2'h0;
    cyc(12);
    chk(standby_filt_n | enable_filt, 1'b0, "mode glitch");
    {standby_select_n, enable_in} = 2'h3;
    cyc(12);
    chk(standby_filt_n & enable_filt, 1'b1, "mode level");
  endtask
  // Wake qualification on both edges and the bias follow.
  task automatic t_wake();
    mode_low_power = 1'b1;
    local_wake_level = 1'b1;
    cyc(30);
    local_wake_level = 1'b0;
    cyc(60);
    chk(wake_flag_r, 1'b0, "short wake");
    chk(bias_r.wake_pull_up, 1'b0, "bias early");
    for (int i = 0; i < 2; i++) begin
      mode_low_power = 1'b1;
      local_wake_level = (i == 0);
      cyc(55);
      chk(wake_flag_r, 1'b1, "wake edge");
      chk(bias_r.wake_pull_up, local_wake_level, "bias up");
      chk(bias_r.wake_pull_down, ~local_wake_level, "bias dn");
      pulse_normal();
    end
    local_wake_level = 1'b1;
    cyc(55);
    chk(wake_flag_r, 1'b0, "wake outside low power");
  endtask
  // Transmit dominant timeout, timer restart and clear by Normal mode.
  task automatic t_txd();
    txd_req = 1'b0;
    cyc(TO - 5);
    txd_req = 1'b1;
    cyc(1);
    txd_req = 1'b0;
    cyc(TO - 5);
    chk(local_fail_r, 1'b0, "timer restart");
    cyc(10);
    chk(tx_enable_r, 1'b0, "txd timeout");
    chk(error_n_r, 1'b0, "error pin");
    txd_req = 1'b1;
    cyc(5);
    chk(tx_enable_r, 1'b0, "held off");
    pulse_normal();
    chk(tx_enable_r & error_n_r, 1'b1, "normal clear");
  endtask
  // Pin short, cleared by receive dominant with transmit recessive.
  task automatic t_short();
    short_en = 1'b1;
    txd_req = 1'b0;
    cyc(3);
    txd_req = 1'b1;
    short_en = 1'b0;
    cyc(2);
    chk(tx_enable_r | ~local_fail_r, 1'b0, "short");
    bus_dominant = 1'b1;
    cyc(2);
    bus_dominant = 1'b0;
    cyc(3);
    chk(tx_enable_r, 1'b1, "receive clear");
  endtask
  // Bus clamp flags only, and drops with the bus.
  task automatic t_bus();
    bus_dominant = 1'b1;
    cyc(TO - 2);
    chk(local_fail_r | rxd_out_r, 1'b0, "bus early");
    cyc(6);
    chk(local_fail_r & tx_enable_r, 1'b1, "bus clamp");
    bus_dominant = 1'b0;
    cyc(1);
    chk(local_fail_r, 1'b0, "bus release");
  endtask
  // Overtemperature shutdown and its two release conditions.
  task automatic t_hot();
    over_temp = 1'b1;
    below_release_temp = 1'b0;
    cyc(2);
    chk(bus_drv_enable_r | tx_enable_r, 1'b0, "hot");
    over_temp = 1'b0;
    pulse_normal();
    chk(tx_enable_r, 1'b0, "still warm");
    below_release_temp = 1'b1;
    cyc(2);
    chk(tx_enable_r, 1'b0, "cool but flagged");
    chk(bus_drv_enable_r, 1'b1, "drivers back");
    pwon_flag = 1'b1;
    cyc(1);
    pwon_flag = 1'b0;
    cyc(3);
    chk(tx_enable_r & bus_drv_enable_r, 1'b1, "cooled");
  endtask
  // Cuts a hang short well past the expected run length.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  // Main sequence.
  initial begin
    cyc(16);
    t_reset();
    t_filter();
    t_wake();
    t_txd();
    t_short();
    t_bus();
    t_hot();
    tally_and_finish();
  end
endmodule
